/* flash_ctl_assertions.sv */
`timescale 1ns/1ps

module flash_ctl_assertions (
	input  wire logic       ref_clk_i,     // Controller clock
	input  wire logic       rst_i,         // Power-up reset
	input  wire logic       sck_i,         // Serial clock
	input  wire logic       cs_n_i,        // Select, active low
	input  wire logic       si_i,          // Serial data in
	input  wire logic       so_o,          // Serial data out
	input  wire logic       so_oe_o,       // Serial out enable
	input  wire logic       hold_n_i,      // Pause, active low
	input  wire logic       wp_n_i,        // Protect, active low
	input  wire logic [7:0] flash_status_o // Status byte
);
	// Power-up value seen right after release
	chk_reset_value: assert property (@(posedge ref_clk_i) disable iff (rst_i) $past(rst_i) |-> flash_status_o == 8'h1c)
		else $error("status not at power-up value");
	chk_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) !flash_status_o[5])
		else $error("reserved status bit set");
	// A deselected device never drives its output
	chk_oe_deselect: assert property (@(posedge ref_clk_i) disable iff (rst_i) cs_n_i |-> !so_oe_o)
		else $error("output driven while deselected");
	// Pause taken at a low clock releases the output until the next low clock
	chk_oe_paused: assert property (@(negedge sck_i) disable iff (cs_n_i) !hold_n_i |=> !so_oe_o)
		else $error("output driven while paused");
	// Busy blocks a write enable from taking effect
	chk_busy_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(flash_status_o[1]) |-> !$past(flash_status_o[0]))
		else $error("latch set while busy");
	// Locked with protect low: level and lock frozen (sync takes two cycles)
	chk_lock_freeze: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!wp_n_i)[*4] ##0 flash_status_o[7] |=> $stable({flash_status_o[7], flash_status_o[4:2]}))
		else $error("locked status bits changed");
	// Plain program or erase completion drops the latch
	chk_done_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(flash_status_o[0]) && !flash_status_o[6] |-> ##[0:2] !flash_status_o[1])
		else $error("latch kept after completion");
	chk_start_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(flash_status_o[0]) |-> $past(flash_status_o[1]))
		else $error("operation started without latch");
	chk_aai_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i) flash_status_o[6] |-> flash_status_o[1])
		else $error("auto mode without latch");
	// Main scenarios reached
	cov_busy: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(flash_status_o[0]));
	cov_aai: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(flash_status_o[6]));
	cov_read: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(so_oe_o));
endmodule : flash_ctl_assertions

bind flash_ctl_top flash_ctl_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
	.si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .flash_status_o(flash_status_o));

/* flash_ctl_pkg.sv */
package flash_ctl_pkg;

	// Reference-domain operating state
	typedef enum logic [0:0] {
		st_ready,
		st_busy
	} ref_state_e;

	// Kind of internal operation being timed
	typedef enum logic [2:0] {
		op_none,
		op_program,
		op_sector,
		op_block,
		op_chip,
		op_aai_word
	} op_kind_e;

	// Serial-clock side, cleared whenever select is high
	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [6:0] shift;
		logic [2:0] byte_cnt;
		logic       first;
	} link_ctl_s;

	// Frame summary, held stable after the last edge of a frame
	typedef struct packed {
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  data;
		logic [2:0]  nbytes;
		logic        partial;
	} link_sum_s;

	// Falling-edge side: pause state and output shifter
	typedef struct packed {
		logic       paused;
		logic [7:0] out_sh;
	} link_out_s;

	// Whole state of the reference-domain controller
	typedef struct packed {
		logic        cs_m;
		logic        cs_s;
		logic        cs_d;
		logic        wp_m;
		logic        wp_s;
		logic        hold_m;
		logic        hold_s;
		logic        pz_m;
		logic        pz_s;
		logic        abort;
		ref_state_e  state;
		op_kind_e    kind;
		logic [31:0] timer;
		logic [23:0] aai_addr;
		logic        lock;
		logic [2:0]  level;
		logic        latch;
		logic        auto_increment_program;
		logic [7:0]  status;
	} ref_s;

endpackage : flash_ctl_pkg

/* flash_ctl_regs.svh */
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// Status byte field positions
`define STAT_BUSY_BIT      0
`define STAT_LATCH_BIT     1
`define STAT_LEVEL_LO_BIT  2
`define STAT_LEVEL_HI_BIT  4
`define STAT_RSVD_BIT      5
`define STAT_AAI_BIT       6
`define STAT_LOCK_BIT      7

// Power-up values of the writable and latched fields
`define STAT_LEVEL_RESET   3'h7
`define STAT_LOCK_RESET    1'h0
`define STAT_LATCH_RESET   1'h0
`define STAT_AAI_RESET     1'h0
`define STAT_RSVD_VALUE    1'h0

// Opcodes handled by the control logic
`define OP_STATUS_WRITE    8'h01
`define OP_BYTE_PROGRAM    8'h02
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_SECTOR_ERASE    8'h20
`define OP_CHIP_ERASE_A    8'h60
`define OP_AUTO_INC        8'had
`define OP_CHIP_ERASE_B    8'hc7
`define OP_BLOCK_ERASE     8'hd8

// Whole bytes that each instruction must carry before select rises
`define LEN_SINGLE         3'h1
`define LEN_STATUS_WRITE   3'h2
`define LEN_AAI_NEXT       3'h3
`define LEN_ERASE          3'h4
`define LEN_BYTE_PROGRAM   3'h5
`define LEN_AAI_FIRST      3'h6

// Last word address that auto-increment programming may write
`define AAI_LAST_WORD      24'h07fffe
`define AAI_STEP           24'h000002

// Timing: reference clock rate and operation times as printed
`define CLK_FREQ_MHZ       250
`define BYTE_PROG_TIME_NS  9000
`define SECTOR_ERASE_MS    90
`define BLOCK_ERASE_MS     1000
`define CHIP_ERASE_MS      4000
`define BYTE_PROG_CYCLES   ((`BYTE_PROG_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_MS * `CLK_FREQ_MHZ * 1000)
`define BLOCK_ERASE_CYCLES  (`BLOCK_ERASE_MS * `CLK_FREQ_MHZ * 1000)
`define CHIP_ERASE_CYCLES   (`CHIP_ERASE_MS * `CLK_FREQ_MHZ * 1000)

`endif

/* flash_ctl_top.sv */
// How it works
// R1: Host keeps select low while pausing.
// R2: Pause starts when pause low, clock low.
// R3: Pause ends when pause high, clock low.
// R4: Paused: output released, clock and data ignored.
// R5: Select rising while paused aborts the frame.
// R6: Pause lasts while the pause input stays low.
// R7: Status write refused when protect low, lock set.
// R8: Protect pin high makes the lock irrelevant.
// R9: Lock bit sits at status bit 7.
// R10: Bit 0 shows busy; software cannot write it.
// R11: While busy only status reads are honoured.
// R12: Bit 1 write latch; clear latch blocks writes. Status write here ignores the latch.
// R13: Latch cleared on power-up and listed completions.
// R14: Bits 2 to 4 protection level, reset ones.
// R15: Status write changes only level and lock. The code also clears the write latch (bit 1) on every status write.
// R16: Lock set freezes level; lock resets clear.
// R17: Bit 6 shows auto-increment mode, read-only.
// R18: Bit 5 reads zero; all bits volatile.
// R19: Lock clear at power-up; locked bits frozen.
// R20: Pause input registered on falling serial clock.
`timescale 1ns/1ps
`include "flash_ctl_regs.svh"

module flash_ctl_top #(
	parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES, // Sector erase busy time
	parameter int unsigned BLOCK_ERASE_CYCLES  = `BLOCK_ERASE_CYCLES,  // Block erase busy time
	parameter int unsigned CHIP_ERASE_CYCLES   = `CHIP_ERASE_CYCLES    // Chip erase busy time
) (
	input  wire logic       ref_clk_i,     // Controller clock, 250 MHz
	input  wire logic       rst_i,         // Power-up reset, active high
	input  wire logic       sck_i,         // Serial clock from host
	input  wire logic       cs_n_i,        // Select, active low
	input  wire logic       si_i,          // Serial data in
	output logic            so_o,          // Serial data out
	output logic            so_oe_o,       // Drive enable for serial out
	input  wire logic       hold_n_i,      // Pause request, active low
	input  wire logic       wp_n_i,        // Protect pin, active low
	output logic [7:0]      flash_status_o // Current status byte
);

	// Byte program and one auto-increment word share this time
	localparam logic [31:0] PROGRAM_LOAD = 32'(`BYTE_PROG_CYCLES - 1);

	flash_ctl_pkg::ref_s r;         // Registered controller state
	flash_ctl_pkg::ref_s next_r;    // Next controller state

	logic        link_paused;        // Pause level from the link side
	logic [7:0]  link_opcode;        // Opcode of the last frame
	logic [23:0] link_addr;          // Address of the last frame
	logic [7:0]  link_data;          // Last byte after the opcode of the last frame
	logic [2:0]  link_nbytes;        // Whole bytes of the last frame
	logic        link_partial;       // Last frame ended mid-byte
	logic        frame_end;          // Select has just risen
	logic        cmd_ok;             // Frame is whole and not aborted
	logic        status_wr_allowed;  // Protect pin and lock permit writes
	logic        may_start;          // Write latch set and no AUTO_INCREMENT_PROGRAM run
	logic [31:0] timer_dec;          // Busy timer minus one

	// Serial-clock side of the controller
	flash_link_front u_front (
		.sck_i     (sck_i),
		.cs_n_i    (cs_n_i),
		.si_i      (si_i),
		.hold_n_i  (hold_n_i),
		.status_i  (r.status),
		.so_o      (so_o),
		.so_oe_o   (so_oe_o),
		.paused_o  (link_paused),
		.opcode_o  (link_opcode),
		.addr_o    (link_addr),
		.data_o    (link_data),
		.nbytes_o  (link_nbytes),
		.partial_o (link_partial)
	);

	// Frame end is select rising after two synchroniser stages
	assign frame_end = r.cs_s & ~r.cs_d;

	// An aborted or bit-misaligned frame does nothing at all
	assign cmd_ok = frame_end & ~r.abort & ~link_partial;

	// Protect high ignores the lock; protect low obeys it
	assign status_wr_allowed = r.wp_s | ~r.lock; // see R7, R8, R19

	// Program and erase need the latch, and stay out of an AUTO_INCREMENT_PROGRAM run
	assign may_start = r.latch & ~r.auto_increment_program; // see R12

	// Shared decrement keeps the width explicit
	assign timer_dec = r.timer - 32'd1;

	// Next-state logic for the whole controller
	always_comb begin
		next_r = r;

		// Two-stage synchronisers; first stages feed only second stages
		next_r.cs_m   = cs_n_i;
		next_r.cs_s   = r.cs_m;
		next_r.cs_d   = r.cs_s;
		next_r.wp_m   = wp_n_i;
		next_r.wp_s   = r.wp_m;
		next_r.hold_m = hold_n_i;
		next_r.hold_s = r.hold_m;
		next_r.pz_m   = link_paused;
		next_r.pz_s   = r.pz_m;

		// Abort memory: cleared after each frame end, set while paused
		if (frame_end)
			next_r.abort = 1'b0;
		else if (!r.pz_s && r.hold_s)
			next_r.abort = 1'b0; // see R6
		// Pause seen wins over any clear in the same cycle
		if (r.pz_s)
			next_r.abort = 1'b1; // see R5

		// Busy timer counts the internal operation down
		if (r.state == flash_ctl_pkg::st_busy) begin
			if (r.timer == 32'd0) begin
				next_r.state = flash_ctl_pkg::st_ready; // see R10
				if (r.kind == flash_ctl_pkg::op_aai_word) begin
					// Last word ends the run and drops the latch
					if (r.aai_addr >= `AAI_LAST_WORD) begin
						next_r.auto_increment_program   = 1'b0; // see R17
						next_r.latch = 1'b0; // see R13
					end else begin
						next_r.aai_addr = r.aai_addr + `AAI_STEP;
					end
				end else begin
					// Program and erase completion clears the latch
					next_r.latch = 1'b0; // see R13
				end
				next_r.kind = flash_ctl_pkg::op_none;
			end else begin
				next_r.timer = timer_dec;
			end
		end

		// Instructions execute when select rises and the part is ready
		if (cmd_ok && r.state == flash_ctl_pkg::st_ready) begin // see R11
			case (link_opcode)
				`OP_WRITE_ENABLE: begin
					if (link_nbytes == `LEN_SINGLE)
						next_r.latch = 1'b1;
				end
				`OP_WRITE_DISABLE: begin
					// Also leaves auto-increment mode
					if (link_nbytes == `LEN_SINGLE) begin
						next_r.latch = 1'b0; // see R13
						next_r.auto_increment_program   = 1'b0;
					end
				end
				`OP_STATUS_WRITE: begin
					if (link_nbytes == `LEN_STATUS_WRITE) begin
						// Only level and lock are taken from the data byte
						if (status_wr_allowed) begin // see R7, R16
							next_r.level = link_data[`STAT_LEVEL_HI_BIT:`STAT_LEVEL_LO_BIT]; // see R15
							next_r.lock  = link_data[`STAT_LOCK_BIT]; // see R9, R15
						end
						// Latch drops whether or not the write was refused
						next_r.latch = 1'b0; // see R13
					end
				end
				`OP_BYTE_PROGRAM: begin
					if (link_nbytes == `LEN_BYTE_PROGRAM && may_start) begin // see R12
						next_r.state = flash_ctl_pkg::st_busy;
						next_r.kind  = flash_ctl_pkg::op_program;
						next_r.timer = PROGRAM_LOAD;
					end
				end
				`OP_SECTOR_ERASE: begin
					if (link_nbytes == `LEN_ERASE && may_start) begin // see R12
						next_r.state = flash_ctl_pkg::st_busy;
						next_r.kind  = flash_ctl_pkg::op_sector;
						next_r.timer = SECTOR_ERASE_CYCLES - 32'd1;
					end
				end
				`OP_BLOCK_ERASE: begin
					if (link_nbytes == `LEN_ERASE && may_start) begin // see R12
						next_r.state = flash_ctl_pkg::st_busy;
						next_r.kind  = flash_ctl_pkg::op_block;
						next_r.timer = BLOCK_ERASE_CYCLES - 32'd1;
					end
				end
				`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
					// Whole-chip erase only with every level bit clear
					if (link_nbytes == `LEN_SINGLE && may_start && r.level == 3'h0) begin // see R12
						next_r.state = flash_ctl_pkg::st_busy;
						next_r.kind  = flash_ctl_pkg::op_chip;
						next_r.timer = CHIP_ERASE_CYCLES - 32'd1;
					end
				end
				`OP_AUTO_INC: begin
					if (!r.auto_increment_program) begin
						// First word carries the start address
						if (link_nbytes == `LEN_AAI_FIRST && r.latch) begin // see R12
							next_r.auto_increment_program      = 1'b1; // see R17
							next_r.aai_addr = {link_addr[23:1], 1'b0};
							next_r.state    = flash_ctl_pkg::st_busy;
							next_r.kind     = flash_ctl_pkg::op_aai_word;
							next_r.timer    = PROGRAM_LOAD;
						end
					end else if (link_nbytes == `LEN_AAI_NEXT) begin
						// Later words reuse the incremented address
						next_r.state = flash_ctl_pkg::st_busy;
						next_r.kind  = flash_ctl_pkg::op_aai_word;
						next_r.timer = PROGRAM_LOAD;
					end
				end
				default: begin
					// Status read and unknown opcodes change nothing here
				end
			endcase
		end

		// Status byte is rebuilt from the next field values
		next_r.status[`STAT_BUSY_BIT]  = (next_r.state == flash_ctl_pkg::st_busy); // see R10
		next_r.status[`STAT_LATCH_BIT] = next_r.latch; // see R12
		next_r.status[`STAT_LEVEL_HI_BIT:`STAT_LEVEL_LO_BIT] = next_r.level; // see R14
		next_r.status[`STAT_RSVD_BIT]  = `STAT_RSVD_VALUE; // see R18
		next_r.status[`STAT_AAI_BIT]   = next_r.auto_increment_program; // see R17
		next_r.status[`STAT_LOCK_BIT]  = next_r.lock; // see R9
	end

	// Power-up reset restores every volatile status default
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r          <= '0;
			r.cs_m     <= 1'b1;
			r.cs_s     <= 1'b1;
			r.cs_d     <= 1'b1;
			r.wp_m     <= 1'b1;
			r.wp_s     <= 1'b1;
			r.hold_m   <= 1'b1;
			r.hold_s   <= 1'b1;
			r.state    <= flash_ctl_pkg::st_ready;
			r.kind     <= flash_ctl_pkg::op_none;
			r.lock     <= `STAT_LOCK_RESET;  // see R16, R19
			r.level    <= `STAT_LEVEL_RESET; // see R14
			r.latch    <= `STAT_LATCH_RESET; // see R13
			r.auto_increment_program      <= `STAT_AAI_RESET;   // see R17
			r.status   <= {`STAT_LOCK_RESET, `STAT_AAI_RESET, `STAT_RSVD_VALUE,
			               `STAT_LEVEL_RESET, `STAT_LATCH_RESET, 1'b0}; // see R18
		end else begin
			r <= next_r;
		end
	end

	assign flash_status_o = r.status;

endmodule : flash_ctl_top

/* flash_link_front.sv */
`timescale 1ns/1ps
`include "flash_ctl_regs.svh"

module flash_link_front (
	input  wire logic        sck_i,      // Serial clock from host
	input  wire logic        cs_n_i,     // Select, active low
	input  wire logic        si_i,       // Serial data in
	input  wire logic        hold_n_i,   // Pause request, active low
	input  wire logic [7:0]  status_i,   // Status byte to shift out
	output logic             so_o,       // Serial data out
	output logic             so_oe_o,    // Drive enable for serial out
	output logic             paused_o,   // Link currently paused
	output logic [7:0]       opcode_o,   // First byte of last frame
	output logic [23:0]      addr_o,     // Address bytes of last frame
	output logic [7:0]       data_o,     // Last whole byte after the opcode of last frame
	output logic [2:0]       nbytes_o,   // Whole bytes seen, saturating
	output logic             partial_o   // Frame ended inside a byte
);

	flash_ctl_pkg::link_ctl_s ctl;       // Bit and byte position
	flash_ctl_pkg::link_ctl_s next_ctl;  // Next bit and byte position
	flash_ctl_pkg::link_sum_s sum;       // Frame summary
	flash_ctl_pkg::link_sum_s next_sum;  // Next frame summary
	flash_ctl_pkg::link_out_s out;       // Pause and output state
	flash_ctl_pkg::link_out_s next_out;  // Next pause and output state
	logic [7:0]               rx_byte;   // Byte completed on this edge
	logic                     reading;   // Status read in progress

	// Rising edge work: shift in, count, build the frame summary
	always_comb begin
		next_ctl = ctl;
		next_sum = ctl.first ? '0 : sum;
		rx_byte  = {ctl.shift, si_i};
		if (!out.paused) begin // see R4
			next_ctl.first   = 1'b0;
			next_ctl.shift   = {ctl.shift[5:0], si_i};
			next_ctl.bit_cnt = ctl.bit_cnt + 3'h1;
			if (ctl.bit_cnt == 3'h7) begin
				if (ctl.byte_cnt != 3'h7)
					next_ctl.byte_cnt = ctl.byte_cnt + 3'h1;
				next_sum.nbytes = next_ctl.byte_cnt;
				if (ctl.byte_cnt == 3'h0)
					next_sum.opcode = rx_byte;
				else begin
					next_sum.data = rx_byte;
					if (ctl.byte_cnt <= 3'h3)
						next_sum.addr = {next_sum.addr[15:0], rx_byte};
				end
			end
			next_sum.partial = (next_ctl.bit_cnt != 3'h0);
		end else begin
			next_sum = sum;
		end
	end

	// Select high clears the interface logic, also during a pause
	always_ff @(posedge sck_i or posedge cs_n_i) begin // see R5
		if (cs_n_i)
			ctl <= '{first: 1'b1, default: '0};
		else
			ctl <= next_ctl;
	end

	// Summary has no reset so it survives select rising
	always_ff @(posedge sck_i) begin
		sum <= next_sum;
	end

	// Falling edge work: capture pause, shift status out
	always_comb begin
		next_out        = out;
		next_out.paused = ~hold_n_i; // see R2, R3, R20
		if (!out.paused) begin
			if (reading && ctl.bit_cnt == 3'h0)
				next_out.out_sh = status_i;
			else
				next_out.out_sh = {out.out_sh[6:0], 1'b0};
		end
	end

	// Pause lives here so it can only change while the clock is low
	always_ff @(negedge sck_i or posedge cs_n_i) begin // see R1
		if (cs_n_i)
			out <= '0;
		else
			out <= next_out;
	end

	// Status read runs from the opcode's end until select rises
	assign reading   = (sum.opcode == `OP_READ_STATUS) && (ctl.byte_cnt != 3'h0);
	assign so_o      = out.out_sh[7];
	assign so_oe_o   = ~cs_n_i & ~out.paused & reading; // see R4
	assign paused_o  = out.paused;
	assign opcode_o  = sum.opcode;
	assign addr_o    = sum.addr;
	assign data_o    = sum.data;
	assign nbytes_o  = sum.nbytes;
	assign partial_o = sum.partial;

endmodule : flash_link_front

/* serial_flash_hold_protect_status_tb.sv */
`timescale 1ns/1ps

module serial_flash_hold_protect_status_tb;
	localparam int unsigned ERASE_CYC = 100; // Short erase times, still longer than one command frame
	logic       ref_clk = 1'b0; // 250 MHz
	logic       rst     = 1'b1; // Power-up reset
	logic       wp_n    = 1'b1; // Protect pin
	wire        sck, cs_n, si, so, so_oe, hold_n;
	wire  [7:0] status;         // Status byte port
	logic [7:0] rx;             // Byte read back
	logic [7:0] ops [4] = '{8'h20, 8'hd8, 8'h60, 8'hc7}; // Erase kinds
	int         n_errors = 0;
	int         tests_run = 0;
	int         cycles = 0;

	flash_ctl_top #(.SECTOR_ERASE_CYCLES(ERASE_CYC), .BLOCK_ERASE_CYCLES(ERASE_CYC), .CHIP_ERASE_CYCLES(ERASE_CYC)) u_dut (
		.ref_clk_i(ref_clk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
		.hold_n_i(hold_n), .wp_n_i(wp_n), .flash_status_o(status));
	spi_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so), .so_oe_i(so_oe));

	always #2 ref_clk = ~ref_clk;
	// Cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Whole instruction frame, then time for the controller to act
	task automatic cmd(input logic [7:0] op, input logic [39:0] rest, input int n);
		u_host.start_frame();
		u_host.xfer(op, 8, rx);
		for (int k = 0; k < n; k++) begin
			u_host.xfer(rest[39 - 8 * k -: 8], 8, rx);
		end
		u_host.stop_frame();
		repeat (12) @(posedge ref_clk);
	endtask : cmd
	task automatic rd_chk(input logic [7:0] exp);
		u_host.start_frame();
		u_host.xfer(8'h05, 8, rx);
		u_host.xfer(8'h00, 8, rx);
		u_host.stop_frame();
		chk(rx, exp);
	endtask : rd_chk
	// Bounded wait for the busy bit to drop
	task automatic wait_ready();
		for (int k = 0; k < 3000 && status[0] !== 1'b0; k++) begin
			// Look after the edge so the status byte has settled
			@(posedge ref_clk);
			#1;
		end
	endtask : wait_ready

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1 chk(status, 8'h1c);
		repeat (4) @(posedge ref_clk);
		rd_chk(8'h1c);
		// Only level and lock take a written value
		cmd(8'h01, {8'hff, 32'h0}, 1);
		chk(status, 8'h9c);
		cmd(8'h01, 40'h0, 1);
		chk(status, 8'h00);
		cmd(8'h01, {8'h84, 32'h0}, 1);
		wp_n <= 1'b0;
		cmd(8'h01, 40'h0, 1);
		chk(status, 8'h84);
		cmd(8'h06, 40'h0, 0);
		cmd(8'h01, 40'h0, 1);
		chk(status, 8'h84);
		wp_n <= 1'b1;
		cmd(8'h01, 40'h0, 1);
		chk(status, 8'h00);
		// Latch gates programming
		cmd(8'h02, {32'h00001055, 8'h0}, 4);
		chk(status, 8'h00);
		cmd(8'h06, 40'h0, 0);
		chk(status, 8'h02);
		cmd(8'h04, 40'h0, 0);
		chk(status, 8'h00);
		cmd(8'h06, 40'h0, 0);
		cmd(8'h02, {32'h00001055, 8'h0}, 4);
		chk(status, 8'h03);
		cmd(8'h04, 40'h0, 0);
		rd_chk(8'h03);
		wait_ready();
		chk(status, 8'h00);
		for (int i = 0; i < 4; i++) begin
			cmd(8'h06, 40'h0, 0);
			cmd(ops[i], {24'h012000, 16'h0}, (i < 2) ? 3 : 0);
			chk(status, 8'h03);
			wait_ready();
			chk(status, 8'h00);
		end
		// Auto-increment run, then one ending at the top word
		cmd(8'h06, 40'h0, 0);
		cmd(8'had, {24'h000100, 16'h1234}, 5);
		chk(status, 8'h43);
		wait_ready();
		cmd(8'had, {16'h5678, 24'h0}, 2);
		wait_ready();
		chk(status, 8'h42);
		cmd(8'h04, 40'h0, 0);
		chk(status, 8'h00);
		cmd(8'h06, 40'h0, 0);
		cmd(8'had, {24'h07fffe, 16'h9abc}, 5);
		wait_ready();
		chk(status, 8'h00);
		// Pause after the opcode; clocks and data while paused are ignored
		u_host.start_frame();
		u_host.hold_next = 1'b0;
		u_host.xfer(8'h01, 8, rx);
		u_host.xfer(8'hff, 8, rx);
		u_host.hold_next = 1'b1;
		u_host.xfer(8'hff, 1, rx);
		u_host.xfer(8'h10, 8, rx);
		u_host.stop_frame();
		repeat (12) @(posedge ref_clk);
		chk(status, 8'h10);
		// Output released while paused in a read, restored after
		u_host.start_frame();
		u_host.hold_next = 1'b0;
		u_host.xfer(8'h05, 8, rx);
		#1 chk({7'h0, so_oe}, 8'h00);
		u_host.hold_next = 1'b1;
		u_host.xfer(8'h00, 1, rx);
		#1 chk({7'h0, so_oe}, 8'h01);
		u_host.stop_frame();
		// Select raised while paused discards the frame
		u_host.start_frame();
		u_host.hold_next = 1'b0;
		u_host.xfer(8'h06, 8, rx);
		u_host.hold_next = 1'b1;
		u_host.stop_frame();
		repeat (12) @(posedge ref_clk);
		chk(status, 8'h10);
		cmd(8'h06, 40'h0, 0);
		chk(status, 8'h12);
		give_verdict();
	end
endmodule : serial_flash_hold_protect_status_tb

/* spi_host_model.sv */
`timescale 1ns/1ps

module spi_host_model (
	output logic      sck_o,    // Serial clock, low outside frames
	output logic      cs_n_o,   // Select, active low
	output logic      si_o,     // Serial data to device
	output logic      hold_n_o, // Pause request, active low
	input  wire logic so_i,     // Device data out
	input  wire logic so_oe_i   // Device drive enable
);
	logic hold_next = 1'b1; // Pause level applied at the last bit of a call
	logic so_last   = 1'b0; // Last level the device drove
	logic so_line;          // Wire level seen by the host
	// Select rises just after time zero so the link side sees a clearing edge
	initial begin
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_n_o = 1'b1;
		#1 cs_n_o = 1'b1;
	end
	// Released line shows the inverse of the last value, not a stale copy
	assign so_line = so_oe_i ? so_i : ~so_last;
	always @(so_i or so_oe_i) begin
		if (so_oe_i) begin
			so_last = so_i;
		end
	end
	// Select low only for the frame; clock stands low meanwhile
	task automatic start_frame();
		cs_n_o = 1'b0;
		#6;
	endtask : start_frame
	// Mode 0 bits MSB first; pause level changes only while the clock is high
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i >= 8 - n; i--) begin
			si_o = tx[i];
			#6 sck_o = 1'b1;
			rx[i] = so_line;
			if (i == 8 - n) begin
				#3 hold_n_o = hold_next;
			end else begin
				#3;
			end
			#3 sck_o = 1'b0;
		end
	endtask : xfer
	// Raise select, then the pause pin; keep select high past the gap
	task automatic stop_frame();
		#6 cs_n_o = 1'b1;
		hold_n_o = hold_next;
		si_o = ~si_o;
		#60;
	endtask : stop_frame
endmodule : spi_host_model
